// *** logic/mbo_regs.svh ***
// register offsets, field positions, reset values and timing counts of the tone output block
`ifndef MBO_REGS_SVH
`define MBO_REGS_SVH
`define MBO_ADDR_W        8
`define MBO_OFS_CTRL      8'h00
`define MBO_OFS_TEMPO     8'h04
`define MBO_OFS_STATUS    8'h08
`define MBO_OFS_MASK      8'h0C
`define MBO_BIT_MODE_LO   0
`define MBO_BIT_MODE_HI   1
`define MBO_BIT_BUZ_EN    2
`define MBO_BIT_MEL_ACT   3
`define MBO_BIT_MEL_START 4
`define MBO_BIT_MEL_END   0
`define MBO_TEMPO_W       4
`define MBO_RST_CTRL      2'h0
`define MBO_RST_TEMPO     4'h0
`define MBO_RESP_OKAY     2'h0
`define MBO_RESP_SLVERR   2'h2
`define MBO_TB_W          15
`define MBO_TAP_DIV8      2
`define MBO_TAP_DIV1024   9
`define MBO_TAP_DIV4096   11
`define MBO_TAP_DIV32768  14
`define MBO_UNIT_LAST     6'h3F
`define MBO_SINGLE_LAST   1'h1
`define MBO_TONE_OFFSET   8'h02
`define MBO_LEN_MIN       6'h01
`endif

// *** logic/mbo_pkg.sv ***
// types shared by the tone output block
`default_nettype none
package mbo_pkg;
   // one melody word as fetched from program memory
   typedef struct packed {
      logic       last;       // final word of a melody
      logic       spare_hi;   // carries no meaning
      logic [5:0] length;     // note length value
      logic       spare_lo;   // carries no meaning
      logic [6:0] tone;       // tone value
   } mbo_melody_word_s;
   // time-base taps and pulses from the low-speed counter
   typedef struct packed {
      logic tick;      // one-cycle pulse per low-speed rising edge
      logic edge_any;  // one-cycle pulse per low-speed edge, either way
      logic div8;      // carrier square wave
      logic div1024;   // single-tone timing tap
      logic div4096;   // intermittent gate
      logic div32768;  // slow gate
      logic fall1024;  // one-cycle pulse on falling div1024
   } mbo_taps_s;
   // buzzer pattern, codes in declaration order
   typedef enum logic [1:0] {BUZ_INTERMITTENT1, BUZ_INTERMITTENT2, BUZ_SINGLE, BUZ_CONTINUOUS} mbo_buz_mode_e;
   // melody sequencer
   typedef enum logic [1:0] {MEL_IDLE, MEL_FETCH, MEL_PLAY} mbo_mel_state_e;
endpackage : mbo_pkg
`default_nettype wire

// *** logic/mbo_timebase.sv ***
// low-speed time-base counter producing taps and edge pulses
`include "mbo_regs.svh"
`default_nettype none
module mbo_timebase
   import mbo_pkg::*;
(
   // clock and reset
   input  wire logic      aclk,
   input  wire logic      aresetn,
   // low-speed clock level, sampled on aclk
   input  wire logic      low_speed_timebase_clock,
   // taps
   output mbo_taps_s      taps
);
   logic                  lsc_prev_ff;   // previous low-speed level
   logic                  nxt_lsc_prev;
   logic [`MBO_TB_W-1:0]  cnt_ff;        // divider chain
   logic [`MBO_TB_W-1:0]  nxt_cnt;
   mbo_taps_s             taps_ff;       // registered taps
   mbo_taps_s             nxt_taps;

   // next counter and taps; counter advances on each low-speed rising edge
   always_comb begin
      nxt_lsc_prev = low_speed_timebase_clock;
      nxt_cnt      = cnt_ff;
      if (low_speed_timebase_clock && !lsc_prev_ff) begin
         nxt_cnt = cnt_ff + 1'b1;
      end
      nxt_taps.tick     = low_speed_timebase_clock & ~lsc_prev_ff;
      nxt_taps.edge_any = low_speed_timebase_clock ^ lsc_prev_ff;
      nxt_taps.div8     = nxt_cnt[`MBO_TAP_DIV8];
      nxt_taps.div1024  = nxt_cnt[`MBO_TAP_DIV1024];
      nxt_taps.div4096  = nxt_cnt[`MBO_TAP_DIV4096];
      nxt_taps.div32768 = nxt_cnt[`MBO_TAP_DIV32768];
      // falling tap seen against the registered copy
      nxt_taps.fall1024 = taps_ff.div1024 & ~nxt_cnt[`MBO_TAP_DIV1024];
   end

   // register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lsc_prev_ff <= 1'b0;
         cnt_ff      <= '0;
         taps_ff     <= '0;
      end else begin
         lsc_prev_ff <= nxt_lsc_prev;
         cnt_ff      <= nxt_cnt;
         taps_ff     <= nxt_taps;
      end
   end

   assign taps = taps_ff;
endmodule : mbo_timebase
`default_nettype wire

// *** logic/mbo_tone_output.sv ***
// melody and buzzer tone output block with axi4-lite registers
//
// Notes on behaviour
// (RL1) word bit 15 marks final melody word
// (RL2) final word starting raises melody-end interrupt
// (RL3) after final note, stop and fetch nothing
// (RL4) word bits 14 and 7 ignored
// (RL5) buzzer enable drives buzzer onto tone pin
// (RL6) two mode bits select four buzzer patterns
// (RL7) carrier is eighth of low-speed clock, square
// (RL8) intermittent 1 gated by 1/4096 tap
// (RL9) intermittent 2: 1/4096 tap and low 1/32768
// (RL10) single tone starts on enable rising
// (RL11) second 1/1024 fall clears enable, stops
// (RL12) continuous sounds while enable stays set
// (RL13) melody active flag suppresses buzzer output
// (RL14) melody start clears enable, melody takes pin
// (RL15) tone is twice low-speed clock over N+2
// (RL16) upper five tone bits zero means silence
// (RL17) length 64 ticks times tempo+1 times L+1
// (RL18) zero length behaves like length one
// (RL19) mode codes 0..3: int1, int2, single, continuous
`include "mbo_regs.svh"
`default_nettype none
module mbo_tone_output
   import mbo_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write address
   input  wire logic [`MBO_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read address
   input  wire logic [`MBO_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // melody word stream
   input  wire mbo_melody_word_s      melody_word,
   input  wire logic                  melody_word_valid,
   output logic                       melody_word_ready,
   // time base and pin
   input  wire logic                  low_speed_timebase_clock,
   output logic                       tone_output_pin,
   // interrupt
   output logic                       irq
);
   mbo_taps_s        taps;                 // time-base taps
   // bus state
   logic             aw_hold_ff,  nxt_aw_hold;   // write address captured
   logic             w_hold_ff,   nxt_w_hold;    // write data captured
   logic [`MBO_ADDR_W-1:0] waddr_ff, nxt_waddr;  // captured write address
   logic [31:0]      wdata_ff,    nxt_wdata;     // captured write data
   logic             wstrb0_ff,   nxt_wstrb0;    // low byte lane enable
   logic             awready_ff,  nxt_awready;
   logic             wready_ff,   nxt_wready;
   logic             bvalid_ff,   nxt_bvalid;
   logic [1:0]       bresp_ff,    nxt_bresp;
   logic             arready_ff,  nxt_arready;
   logic             rvalid_ff,   nxt_rvalid;
   logic [31:0]      rdata_ff,    nxt_rdata;
   logic [1:0]       rresp_ff,    nxt_rresp;
   // control state
   logic [1:0]       mode_ff,     nxt_mode;      // buzzer pattern select
   logic             buzzer_enable_ff, nxt_buzzer_enable;
   logic             buz_en_prev_ff,   nxt_buz_en_prev;
   logic             single_run_ff,    nxt_single_run;  // single tone in progress
   logic             single_falls_ff,  nxt_single_falls;
   logic [`MBO_TEMPO_W-1:0] tempo_ff, nxt_tempo;
   logic             status_ff,   nxt_status;    // sticky melody end
   logic             mask_ff,     nxt_mask;
   logic             irq_ff,      nxt_irq;
   // melody state
   mbo_mel_state_e   mel_state_ff, nxt_mel_state;
   logic             melody_active_flag;          // melody owns the pin
   logic             word_ready_ff, nxt_word_ready;
   logic             last_ff,     nxt_last;       // current note is final
   logic [6:0]       tone_ff,     nxt_tone;
   logic [11:0]      note_total_ff, nxt_note_total; // units of 64 ticks
   logic [11:0]      note_cnt_ff, nxt_note_cnt;
   logic [5:0]       unit_cnt_ff, nxt_unit_cnt;
   logic [7:0]       tone_cnt_ff, nxt_tone_cnt;   // low-speed edge count in period
   logic             pin_ff,      nxt_pin;
   // combinational helpers
   logic             wr_fire;                     // write performed this cycle
   logic             rd_fire;                     // read accepted this cycle
   logic             start_req;                   // software melody start
   logic [5:0]       len_eff;
   logic [4:0]       tempo_plus;
   logic [6:0]       len_plus;
   logic [7:0]       tone_period;
   logic             tone_silent;
   logic             melody_wave;
   logic             buz_gate;
   logic             buzzer_wave;

   // divider chain on the low-speed clock
   mbo_timebase u_timebase (
      .aclk                     (aclk),
      .aresetn                  (aresetn),
      .low_speed_timebase_clock (low_speed_timebase_clock),
      .taps                     (taps)
   );

   assign melody_active_flag = (mel_state_ff != MEL_IDLE);

   // next state of everything; bus decode, buzzer, melody and pin
   always_comb begin
      nxt_aw_hold = aw_hold_ff;
      nxt_w_hold  = w_hold_ff;
      nxt_waddr   = waddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb0  = wstrb0_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      nxt_mode    = mode_ff;
      nxt_buzzer_enable = buzzer_enable_ff;
      nxt_tempo   = tempo_ff;
      nxt_mask    = mask_ff;
      nxt_status  = status_ff;
      start_req   = 1'b0;
      // capture address and data in either order
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_hold = 1'b1;
         nxt_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_hold = 1'b1;
         nxt_wdata  = s_axi_wdata;
         nxt_wstrb0 = s_axi_wstrb[0];
      end
      wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
      if (wr_fire) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = `MBO_RESP_OKAY;
         unique case (waddr_ff)
            `MBO_OFS_CTRL: if (wstrb0_ff) begin
               nxt_mode          = {wdata_ff[`MBO_BIT_MODE_HI], wdata_ff[`MBO_BIT_MODE_LO]}; // [RL6]
               nxt_buzzer_enable = wdata_ff[`MBO_BIT_BUZ_EN];
               start_req         = wdata_ff[`MBO_BIT_MEL_START];
            end
            `MBO_OFS_TEMPO:  if (wstrb0_ff) nxt_tempo = wdata_ff[`MBO_TEMPO_W-1:0];
            `MBO_OFS_MASK:   if (wstrb0_ff) nxt_mask  = wdata_ff[`MBO_BIT_MEL_END];
            `MBO_OFS_STATUS: nxt_bresp = `MBO_RESP_OKAY; // read-to-clear, writes ignored
            default:         nxt_bresp = `MBO_RESP_SLVERR;
         endcase
      end
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      // read channel; status clears on read
      rd_fire = s_axi_arvalid && arready_ff;
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (rd_fire) begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = '0;
         nxt_rresp  = `MBO_RESP_OKAY;
         unique case (s_axi_araddr)
            `MBO_OFS_CTRL: begin
               nxt_rdata[`MBO_BIT_MODE_LO] = mode_ff[0];
               nxt_rdata[`MBO_BIT_MODE_HI] = mode_ff[1];
               nxt_rdata[`MBO_BIT_BUZ_EN]  = buzzer_enable_ff;
               nxt_rdata[`MBO_BIT_MEL_ACT] = melody_active_flag;
            end
            `MBO_OFS_TEMPO:  nxt_rdata[`MBO_TEMPO_W-1:0] = tempo_ff;
            `MBO_OFS_STATUS: begin
               nxt_rdata[`MBO_BIT_MEL_END] = status_ff;
               nxt_status = 1'b0;
            end
            `MBO_OFS_MASK:   nxt_rdata[`MBO_BIT_MEL_END] = mask_ff;
            default:         nxt_rresp = `MBO_RESP_SLVERR;
         endcase
      end
      nxt_awready = !nxt_aw_hold && !nxt_bvalid;
      nxt_wready  = !nxt_w_hold && !nxt_bvalid;
      nxt_arready = !nxt_rvalid;

      // melody sequencer
      nxt_mel_state  = mel_state_ff;
      nxt_word_ready = word_ready_ff;
      nxt_last       = last_ff;
      nxt_tone       = tone_ff;
      nxt_note_total = note_total_ff;
      nxt_note_cnt   = note_cnt_ff;
      nxt_unit_cnt   = unit_cnt_ff;
      nxt_tone_cnt   = tone_cnt_ff;
      len_eff        = (melody_word.length == '0) ? `MBO_LEN_MIN : melody_word.length; // [RL18]
      tempo_plus     = {1'b0, tempo_ff} + 5'h01;
      len_plus       = {1'b0, len_eff} + 7'h01;
      tone_period    = {1'b0, tone_ff} + `MBO_TONE_OFFSET;
      unique case (mel_state_ff)
         MEL_IDLE: begin
            if (start_req) begin
               nxt_mel_state  = MEL_FETCH;
               nxt_word_ready = 1'b1;
            end
         end
         MEL_FETCH: begin
            if (melody_word_valid && word_ready_ff) begin
               // spare bits 14 and 7 are never looked at
               nxt_word_ready = 1'b0; // [RL4]
               nxt_last       = melody_word.last; // [RL1]
               nxt_tone       = melody_word.tone;
               nxt_note_total = 12'(tempo_plus) * 12'(len_plus); // [RL17]
               nxt_note_cnt   = '0;
               nxt_unit_cnt   = '0;
               nxt_tone_cnt   = '0;
               nxt_mel_state  = MEL_PLAY;
               if (melody_word.last) begin
                  nxt_status = 1'b1; // [RL2]
               end
            end
         end
         MEL_PLAY: begin
            if (taps.edge_any) begin
               // one tone period spans N+2 low-speed edges
               nxt_tone_cnt = (tone_cnt_ff >= tone_period - 8'h01) ? 8'h00 : tone_cnt_ff + 8'h01; // [RL15]
            end
            if (taps.tick) begin
               nxt_unit_cnt = unit_cnt_ff + 6'h01;
               if (unit_cnt_ff == `MBO_UNIT_LAST) begin
                  nxt_note_cnt = note_cnt_ff + 12'h001;
                  if (note_cnt_ff == note_total_ff - 12'h001) begin
                     // final note ends the melody with no further fetch
                     nxt_mel_state  = last_ff ? MEL_IDLE : MEL_FETCH; // [RL3]
                     nxt_word_ready = !last_ff;
                  end
               end
            end
         end
      endcase

      // buzzer enable edge and single-tone timing
      nxt_buz_en_prev  = buzzer_enable_ff;
      nxt_single_run   = single_run_ff;
      nxt_single_falls = single_falls_ff;
      if (buzzer_enable_ff && !buz_en_prev_ff && mode_ff == BUZ_SINGLE) begin
         nxt_single_run   = 1'b1; // [RL10]
         nxt_single_falls = 1'b0;
      end else if (single_run_ff && taps.fall1024) begin
         nxt_single_falls = 1'b1;
         if (single_falls_ff == `MBO_SINGLE_LAST) begin
            nxt_single_run    = 1'b0; // [RL11]
            nxt_buzzer_enable = 1'b0; // [RL11]
         end
      end
      if (!nxt_buzzer_enable) begin
         nxt_single_run = 1'b0;
      end
      // melody start takes the pin from the buzzer
      if (mel_state_ff == MEL_IDLE && start_req) begin
         nxt_buzzer_enable = 1'b0; // [RL14]
         nxt_single_run    = 1'b0; // [RL14]
         nxt_buz_en_prev   = 1'b0;
      end

      // pattern gate; codes in mode type order
      unique case (mbo_buz_mode_e'(mode_ff)) // [RL19]
         BUZ_INTERMITTENT1: buz_gate = taps.div4096; // [RL8]
         BUZ_INTERMITTENT2: buz_gate = taps.div4096 & ~taps.div32768; // [RL9]
         BUZ_SINGLE:        buz_gate = single_run_ff;
         BUZ_CONTINUOUS:    buz_gate = 1'b1; // [RL12]
      endcase
      buzzer_wave = buzzer_enable_ff & buz_gate & taps.div8; // [RL5] [RL7]
      tone_silent = (tone_ff[6:2] == 5'h00); // [RL16]
      melody_wave = (mel_state_ff == MEL_PLAY) && !tone_silent && (tone_cnt_ff < {1'b0, tone_period[7:1]});
      // buzzer never reaches the pin while the melody owns it
      nxt_pin = melody_active_flag ? melody_wave : buzzer_wave; // [RL13]
      nxt_irq = nxt_status & nxt_mask;
   end

   // register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         waddr_ff   <= '0;
         wdata_ff   <= '0;
         wstrb0_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `MBO_RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= `MBO_RESP_OKAY;
         mode_ff    <= `MBO_RST_CTRL;
         buzzer_enable_ff <= 1'b0;
         buz_en_prev_ff   <= 1'b0;
         single_run_ff    <= 1'b0;
         single_falls_ff  <= 1'b0;
         tempo_ff   <= `MBO_RST_TEMPO;
         status_ff  <= 1'b0;
         mask_ff    <= 1'b0;
         irq_ff     <= 1'b0;
         mel_state_ff  <= MEL_IDLE;
         word_ready_ff <= 1'b0;
         last_ff       <= 1'b0;
         tone_ff       <= '0;
         note_total_ff <= '0;
         note_cnt_ff   <= '0;
         unit_cnt_ff   <= '0;
         tone_cnt_ff   <= '0;
         pin_ff        <= 1'b0;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff  <= nxt_w_hold;
         waddr_ff   <= nxt_waddr;
         wdata_ff   <= nxt_wdata;
         wstrb0_ff  <= nxt_wstrb0;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
         mode_ff    <= nxt_mode;
         buzzer_enable_ff <= nxt_buzzer_enable;
         buz_en_prev_ff   <= nxt_buz_en_prev;
         single_run_ff    <= nxt_single_run;
         single_falls_ff  <= nxt_single_falls;
         tempo_ff   <= nxt_tempo;
         status_ff  <= nxt_status;
         mask_ff    <= nxt_mask;
         irq_ff     <= nxt_irq;
         mel_state_ff  <= nxt_mel_state;
         word_ready_ff <= nxt_word_ready;
         last_ff       <= nxt_last;
         tone_ff       <= nxt_tone;
         note_total_ff <= nxt_note_total;
         note_cnt_ff   <= nxt_note_cnt;
         unit_cnt_ff   <= nxt_unit_cnt;
         tone_cnt_ff   <= nxt_tone_cnt;
         pin_ff        <= nxt_pin;
      end
   end

   // outputs straight from flops
   assign s_axi_awready     = awready_ff;
   assign s_axi_wready      = wready_ff;
   assign s_axi_bvalid      = bvalid_ff;
   assign s_axi_bresp       = bresp_ff;
   assign s_axi_arready     = arready_ff;
   assign s_axi_rvalid      = rvalid_ff;
   assign s_axi_rdata       = rdata_ff;
   assign s_axi_rresp       = rresp_ff;
   assign melody_word_ready = word_ready_ff;
   assign tone_output_pin   = pin_ff;
   assign irq               = irq_ff;
endmodule : mbo_tone_output
`default_nettype wire

// *** bench/mbo_tone_output_monitor.sv ***
// port checker of the tone output block
`default_nettype none
module mbo_tone_monitor
   import mbo_pkg::*;
(
   // clock and reset
   input wire logic             aclk,
   input wire logic             aresetn,
   // register bus
   input wire logic [7:0]       s_axi_awaddr,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic [1:0]       s_axi_bresp,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic [7:0]       s_axi_araddr,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [1:0]       s_axi_rresp,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   // melody stream, pin, interrupt
   input wire mbo_melody_word_s melody_word,
   input wire logic             melody_word_valid,
   input wire logic             melody_word_ready,
   input wire logic             tone_output_pin,
   input wire logic             irq
);
   // one clock domain
   default clocking mc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rvalid dropped");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
   r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read late");
   bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad read accepted");
   bad_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr > 8'h0C |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2) else $error("unmapped write");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
      else $error("upper bits set");
   word_drop_a: assert property (melody_word_valid && melody_word_ready |=> !melody_word_ready [*8])
      else $error("ready too soon");
   silent_pin_a: assert property (melody_word_valid && melody_word_ready && melody_word.tone[6:2] == 5'h0
      |-> ##6 !tone_output_pin [*8]) else $error("rest not silent");
   // main scenarios reached
   cover property (melody_word_valid && melody_word_ready && melody_word.last);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property ($rose(irq));
endmodule : mbo_tone_monitor
bind mbo_tone_output mbo_tone_monitor mon_u (.*);
`default_nettype wire

// *** bench/mbo_transducer.sv ***
// sound transducer model: counts tone pin rises
`default_nettype none
module mbo_transducer (
   // clock and pin
   input  wire logic   aclk,
   input  wire logic   tone_output_pin,
   // count control
   input  wire logic   clr,
   output logic [15:0] rises
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pin_ff;  // previous pin level
   // a piezo hears level changes, so count rises
   always_ff @(posedge aclk) begin
      pin_ff <= tone_output_pin;
      if (clr) rises <= 16'h0;
      else if (tone_output_pin && !pin_ff) rises <= rises + 16'h1;
   end
endmodule : mbo_transducer
`default_nettype wire

// *** bench/mbo_tone_output_tb.sv ***
// self-checking bench of the tone output block
`default_nettype none
module mbo_tone_output_tb
   import mbo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // clock, reset, slow clock at aclk/4
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [1:0] ls_div = 2'h0;
   wire low_speed_timebase_clock = ls_div[1];
   // bus and stream drive
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, tone_output_pin;
   logic [1:0] s_axi_bresp, s_axi_rresp, t;
   mbo_melody_word_s melody_word = '0, w;
   logic melody_word_valid = 1'b0, melody_word_ready, clr = 1'b0;
   // checking state
   logic [15:0] seed = 16'h0017, rises;
   logic [6:0] n;
   int fails = 0, samples_checked = 0, len;

   always #25 aclk = ~aclk;
   always @(posedge aclk) ls_div <= ls_div + 2'h1;
   mbo_tone_output dut_u (.*);
   mbo_transducer load_u (.*);

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // single tone clears its enable
   function automatic logic [31:0] exp_ctrl(input logic [1:0] m);
      return {29'h0, m != 2'h2, m};
   endfunction : exp_ctrl
   // pin rises in a note of 128*(tempo+1) ticks
   function automatic int exp_rises(input logic [1:0] tp, input logic [6:0] tn);
      return 256 * (tp + 1) / (tn + 2);
   endfunction : exp_rises
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t saw %h not %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // a spent wait bound ends the run
   task automatic hang(input int i);
      if (i >= 99) begin
         fails++;
         results();
      end
   endtask : hang
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 99; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      hang(i);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 99; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      hang(i);
      d = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic cnt_clr();
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
   endtask : cnt_clr
   // offer a word, time the note
   task automatic note(input mbo_melody_word_s wd);
      int i;
      melody_word <= wd;
      melody_word_valid <= 1'b1;
      for (i = 0; i < 99; i++) begin
         @(posedge aclk);
         if (melody_word_ready) break;
      end
      hang(i);
      melody_word_valid <= 1'b0;
      cnt_clr();
      for (len = 1; len < 2200 && !melody_word_ready; len++) @(posedge aclk);
   endtask : note

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values, unmapped refused
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4), (i == 4) ? 2'h2 : 2'h0);
         chk(d, 32'h0);
      end
      wr(8'h10, 32'h1, 2'h2);
      seed = lfsr(seed);
      t = seed[1:0];
      wr(8'h04, {30'h0, t}, 2'h0);
      rd(8'h04, 2'h0);
      chk(d, {30'h0, t});
      // every buzzer pattern for 9000 cycles
      for (int m = 2; m < 6; m++) begin
         wr(8'h00, {30'h1, 2'(m)}, 2'h0);
         cnt_clr();
         repeat (9000) @(posedge aclk);
         rd(8'h00, 2'h0);
         chk(d, exp_ctrl(2'(m)));
         if (m == 3) chk({31'h0, rises >= 16'h10E && rises <= 16'h122}, 32'h1);
         if (m == 2) chk({31'h0, rises >= 16'h7F && rises <= 16'h104}, 32'h1);
      end
      wr(8'h00, 32'h0, 2'h0);
      cnt_clr();
      repeat (200) @(posedge aclk);
      chk({16'h0, rises}, 32'h0);
      // melody over a sounding buzzer
      wr(8'h0C, 32'h1, 2'h0);
      wr(8'h00, 32'h7, 2'h0);
      wr(8'h00, 32'h17, 2'h0);
      rd(8'h00, 2'h0);
      chk(d, 32'hB);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         n = 7'h4 + 7'(seed % 16'h7C);
         w = {i == 2, seed[3], (i == 1) ? 6'h1 : 6'h0, seed[9], (i == 2) ? {5'h0, seed[1:0]} : n};
         note(w);
         if (i < 2) chk({31'h0, len >= 512 * (t + 1) - 4 && len <= 512 * (t + 1) + 16}, 32'h1);
         if (i < 2) chk({31'h0, rises + 1 >= exp_rises(t, n) && rises <= exp_rises(t, n) + 1}, 32'h1);
      end
      chk({16'h0, rises}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, melody_word_ready}, 32'h0);
      rd(8'h00, 2'h0);
      chk(d, 32'h3);
      rd(8'h08, 2'h0);
      chk(d, 32'h1);
      rd(8'h08, 2'h0);
      chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
      results();
   end
endmodule : mbo_tone_output_tb
`default_nettype wire
